// ==== tb/vector_frame_buffer_writer_tb_top.sv ====
// Bench top for the vector frame buffer writer
`timescale 1ns/1ps
`include "vfb_defines.vh"
module vector_frame_buffer_writer_tb_top;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  wire [7:0] cmd_data;
  wire [3:0] cmd_code;
  wire cmd_strobe;
  wire cmd_wait_reg;
  wire [7:0] wr_x_reg;
  wire [7:0] wr_y_reg;
  wire hsync_reg;
  wire vsync_reg;
  wire hblank_reg;
  wire vblank_reg;
  wire [2:0] rgb_reg;
  localparam integer PIX = 2;
  integer err_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  always #2 sys_clk = ~sys_clk;
  // Short pixel tick keeps two raster lines inside the run
  vfb_frame_writer #(.PIX_DIV(PIX)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_data(cmd_data),
    .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .cmd_wait_reg(cmd_wait_reg), .wr_x_reg(wr_x_reg),
    .wr_y_reg(wr_y_reg), .hsync_reg(hsync_reg), .vsync_reg(vsync_reg), .hblank_reg(hblank_reg),
    .vblank_reg(vblank_reg), .rgb_reg(rgb_reg));
  vfb_host_model u_host (.sys_clk(sys_clk), .cmd_wait_reg(cmd_wait_reg), .cmd_data(cmd_data),
    .cmd_code(cmd_code), .cmd_strobe(cmd_strobe));
  task check(input string what, input [7:0] exp, input [7:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count = err_count + 1;
    end
  end
  endtask
  task stop_test;
  begin
    $display("Mismatches %0d of %0d comparisons", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // Hang guard, far above the expected two thousand cycles
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  // ==================================================
  // Scenarios
  task t_load;
  begin
    u_host.send(`VFB_CMD_LOAD_X, 8'hFF, 1'b0);
    u_host.send(`VFB_CMD_LOAD_Y, 8'h00, 1'b0);
    check("wr_x", 8'hFF, wr_x_reg);
    check("wr_y", 8'h00, wr_y_reg);
  end
  endtask
  task t_step;
  begin
    u_host.send(`VFB_CMD_STEP, 8'h01, 1'b0);
    check("wr_x", 8'h00, wr_x_reg);
    u_host.send(`VFB_CMD_STEP, 8'h0C, 1'b0);
    check("wr_y", 8'hFF, wr_y_reg);
    u_host.send(`VFB_CMD_STEP, 8'h0F, 1'b0);
    check("wr_x", 8'hFF, wr_x_reg);
    check("wr_y", 8'hFE, wr_y_reg);
    u_host.send(`VFB_CMD_STEP, 8'h00, 1'b0);
    check("wr_x", 8'hFF, wr_x_reg);
  end
  endtask
  task t_refuse;
  begin
    u_host.send(`VFB_CMD_LOAD_X, 8'h20, 1'b1);
    u_host.send(`VFB_CMD_LOAD_X, 8'h99, 1'b0);
    check("wr_x", 8'h20, wr_x_reg);
    check("wait", 8'h00, {7'h00, cmd_wait_reg});
  end
  endtask
  task t_other;
  begin
    u_host.send(`VFB_CMD_SET_COLOUR, 8'h07, 1'b0);
    u_host.send(4'hF, 8'h55, 1'b0);
    u_host.send(`VFB_CMD_NOP, 8'hAA, 1'b0);
    check("wr_x", 8'h20, wr_x_reg);
    check("wr_y", 8'hFE, wr_y_reg);
  end
  endtask
  // Two pixels on line 1, looked at while the raster shows them
  task t_pixel;
  begin
    u_host.send(`VFB_CMD_SET_COLOUR, 8'h05, 1'b0);
    u_host.send(`VFB_CMD_LOAD_Y, 8'h01, 1'b0);
    u_host.send(`VFB_CMD_LOAD_X, 8'h40, 1'b0);
    // Line 1 starts at this fall; pixel h shows P*(h+1) edges later
    @(negedge hblank_reg);
    repeat (PIX * 8'h21 + 1) @(negedge sys_clk);
    check("rgb", 8'h05, {5'h00, rgb_reg});
    check("vblank", 8'h00, {7'h00, vblank_reg});
    check("vsync", 8'h00, {7'h00, vsync_reg});
    repeat (PIX * 8'h20) @(negedge sys_clk);
    check("rgb", 8'h05, {5'h00, rgb_reg});
    check("hblank", 8'h00, {7'h00, hblank_reg});
  end
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_load;
    t_step;
    t_refuse;
    t_other;
    t_pixel;
    // Idle lines so the sync checks see two line starts
    repeat (1500) @(negedge sys_clk);
    stop_test;
  end
endmodule // vector_frame_buffer_writer_tb_top
bind vfb_frame_writer vfb_frame_monitor #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL), .PIX_DIV(PIX_DIV)) u_mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_data(cmd_data), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
  .cmd_wait_reg(cmd_wait_reg), .wr_x_reg(wr_x_reg), .wr_y_reg(wr_y_reg), .hsync_reg(hsync_reg),
  .hblank_reg(hblank_reg), .vblank_reg(vblank_reg), .rgb_reg(rgb_reg));

// ==== tb/vfb_frame_monitor.sv ====
// Port checker for the frame writer
`timescale 1ns/1ps
module vfb_frame_monitor #(
  parameter H_TOTAL = 320,
  parameter V_TOTAL = 262,
  parameter PIX_DIV = 5
)
(
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] cmd_data,
  input wire [3:0] cmd_code,
  input wire cmd_strobe,
  input wire cmd_wait_reg,
  input wire [7:0] wr_x_reg,
  input wire [7:0] wr_y_reg,
  input wire hsync_reg,
  input wire hblank_reg,
  input wire vblank_reg,
  input wire [2:0] rgb_reg
);
  localparam int HP = H_TOTAL * PIX_DIV;
  wire take = cmd_strobe & ~cmd_wait_reg;
  reg [7:0] data_reg;
  reg hs_prev_reg;
  reg hs_seen_reg;
  reg [15:0] hs_cnt_reg;
  // Accepted byte and line counter; no new take lands inside a check window
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_reg <= 8'h00;
      hs_prev_reg <= 1'b0;
      hs_seen_reg <= 1'b0;
      hs_cnt_reg <= 16'h0000;
    end
    else
    begin
      hs_prev_reg <= hsync_reg;
      if (take)
        data_reg <= cmd_data;
      if (hsync_reg & ~hs_prev_reg)
      begin
        hs_seen_reg <= 1'b1;
        hs_cnt_reg <= 16'h0001;
      end
      else
        hs_cnt_reg <= hs_cnt_reg + 16'h0001;
    end
  end
  // ==================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_wait_rises: assert property (take |=> cmd_wait_reg) else $error("wait not raised");
  a_wait_bound: assert property ($rose(cmd_wait_reg) |-> ##[1:5] !cmd_wait_reg) else $error("wait stuck");
  a_other_code: assert property (take && cmd_code == 4'hF |=> cmd_wait_reg ##[1:2] !cmd_wait_reg)
    else $error("odd code");
  a_load_x: assert property (take && cmd_code == 4'h1 |-> ##4 wr_x_reg == data_reg) else $error("load x");
  a_load_y: assert property (take && cmd_code == 4'h2 |-> ##4 wr_y_reg == data_reg) else $error("load y");
  a_step_xup: assert property (take && cmd_code == 4'h4 && cmd_data[1:0] == 2'b01
    |-> ##4 wr_x_reg == $past(wr_x_reg, 4) + 8'h01) else $error("step x up");
  a_step_ydown: assert property (take && cmd_code == 4'h4 && cmd_data[3:2] == 2'b11
    |-> ##4 wr_y_reg == $past(wr_y_reg, 4) - 8'h01) else $error("step y down");
  a_xy_idle: assert property (!cmd_wait_reg && !cmd_strobe |=> $stable({wr_x_reg, wr_y_reg}))
    else $error("counter moved");
  a_hsync_period: assert property (hs_seen_reg && hsync_reg && !hs_prev_reg |-> hs_cnt_reg == HP)
    else $error("line length");
  a_hsync_width: assert property (!hsync_reg && hs_prev_reg |-> hs_cnt_reg == 24 * PIX_DIV)
    else $error("sync width");
  a_blank_black: assert property (hblank_reg || vblank_reg |=> rgb_reg == 3'h0)
    else $error("colour in blank");
  c_load: cover property (take && cmd_code == 4'h1);
  c_step: cover property (take && cmd_code == 4'h4);
  c_refused: cover property (cmd_strobe && cmd_wait_reg);
endmodule // vfb_frame_monitor

// ==== tb/vfb_host_model.sv ====
// Game processor model driving the command port
`timescale 1ns/1ps
module vfb_host_model
(
  input wire sys_clk,
  input wire cmd_wait_reg,
  output reg [7:0] cmd_data,
  output reg [3:0] cmd_code,
  output reg cmd_strobe
);
  initial
  begin
    cmd_data = 8'h00;
    cmd_code = 4'h0;
    cmd_strobe = 1'b0;
  end
  // One command; hold set returns at once so a refused strobe can follow
  task send(input [3:0] code, input [7:0] data, input hold);
    integer n;
    begin
      @(negedge sys_clk);
      cmd_code = code;
      cmd_data = data;
      cmd_strobe = 1'b1;
      @(negedge sys_clk);
      cmd_strobe = 1'b0;
      // Released byte inverted so a stale value cannot pass
      cmd_data = ~data;
      for (n = 0; n < 20 && cmd_wait_reg && !hold; n = n + 1)
        @(negedge sys_clk);
    end
  endtask
endmodule // vfb_host_model

// ==== verilog/vfb_defines.vh ====
// Constants for the vector frame buffer writer
`ifndef VFB_DEFINES_VH
`define VFB_DEFINES_VH
// =====================================================
// Control codes on the 4-bit command port
`define VFB_CMD_NOP 4'h0
`define VFB_CMD_LOAD_X 4'h1
`define VFB_CMD_LOAD_Y 4'h2
`define VFB_CMD_SET_COLOUR 4'h3
`define VFB_CMD_STEP 4'h4
// =====================================================
// Field positions in the data byte for a step
`define VFB_STEP_X_EN 0
`define VFB_STEP_X_DOWN 1
`define VFB_STEP_Y_EN 2
`define VFB_STEP_Y_DOWN 3
// Colour bits in the data byte for set colour
`define VFB_COL_RED 0
`define VFB_COL_GREEN 1
`define VFB_COL_BLUE 2
// =====================================================
// Raster timing counts, in pixel clocks and lines; the divider in system clocks per pixel
`define VFB_H_TOTAL 320
`define VFB_H_SYNC_START 272
`define VFB_H_SYNC_END 296
`define VFB_V_TOTAL 262
`define VFB_V_SYNC_START 260
`define VFB_V_SYNC_END 262
`define VFB_PIX_DIV 5
`endif

// ==== verilog/vfb_frame_writer.v ====
// Top of the vector frame buffer writer: planes, write counters, arbitration
`timescale 1ns/1ps
`include "vfb_defines.vh"
module vfb_frame_writer #(
  parameter H_TOTAL = `VFB_H_TOTAL,
  parameter V_TOTAL = `VFB_V_TOTAL,
  parameter PIX_DIV = `VFB_PIX_DIV
)
(
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] cmd_data,
  input wire [3:0] cmd_code,
  input wire cmd_strobe,
  output reg cmd_wait_reg,
  output reg [7:0] wr_x_reg,
  output reg [7:0] wr_y_reg,
  output reg hsync_reg,
  output reg vsync_reg,
  output reg hblank_reg,
  output reg vblank_reg,
  output reg [2:0] rgb_reg
);
  // =====================================================
  // Storage: one bit per pixel per colour plane
  // Nothing clears them at reset; the host paints the screen itself
  // Word address is {Y, X}, so the 256 x 256 frame fills every word
  reg plane_r [0:65535];
  reg plane_g [0:65535];
  reg plane_b [0:65535];

  wire pix_tick;
  wire [8:0] h_cnt;
  wire [8:0] v_cnt;

  reg [3:0] pend_code_reg;
  reg [7:0] pend_data_reg;
  reg pend_reg;
  reg [2:0] colour_reg;
  reg do_write_reg;
  reg [2:0] rd_bits_reg;
  reg rd_active_reg;
  reg [7:0] wr_x_next;
  reg [7:0] wr_y_next;
  reg [2:0] colour_next;
  reg write_next;

  // =====================================================
  // Read side: raster counters in a leaf module
  // Leaf also supplies the pixel tick that paces the read slots
  vfb_raster_timer #(
    .H_TOTAL(H_TOTAL),
    .V_TOTAL(V_TOTAL),
    .PIX_DIV(PIX_DIV)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pix_tick_reg(pix_tick),
    .h_cnt_reg(h_cnt),
    .v_cnt_reg(v_cnt)
  );

  // Step one coordinate up or down when enabled
  // Counters wrap at the frame edge, 255 to 0 and back
  function [7:0] step_coord;
    input [7:0] cur;
    input en;
    input down;
    begin
      if (!en)
        step_coord = cur;
      else if (down)
        step_coord = cur - 8'h01;
      else
        step_coord = cur + 8'h01;
    end
  endfunction

  // =====================================================
  // Decode of the held request; only address changes write
  // Step with no axis enabled moves nothing and so stores nothing
  always @*
  begin
    wr_x_next = wr_x_reg;
    wr_y_next = wr_y_reg;
    colour_next = colour_reg;
    write_next = 1'b0;
    case (pend_code_reg)
      `VFB_CMD_LOAD_X:
      begin
        wr_x_next = pend_data_reg;
        write_next = 1'b1;
      end
      `VFB_CMD_LOAD_Y:
      begin
        wr_y_next = pend_data_reg;
        write_next = 1'b1;
      end
      `VFB_CMD_SET_COLOUR:
        colour_next = {pend_data_reg[`VFB_COL_BLUE], pend_data_reg[`VFB_COL_GREEN], pend_data_reg[`VFB_COL_RED]};
      `VFB_CMD_STEP:
      begin
        wr_x_next = step_coord(wr_x_reg, pend_data_reg[`VFB_STEP_X_EN], pend_data_reg[`VFB_STEP_X_DOWN]);
        wr_y_next = step_coord(wr_y_reg, pend_data_reg[`VFB_STEP_Y_EN], pend_data_reg[`VFB_STEP_Y_DOWN]);
        write_next = pend_data_reg[`VFB_STEP_X_EN] | pend_data_reg[`VFB_STEP_Y_EN];
      end
      default:
        write_next = 1'b0;
    endcase
  end

  // =====================================================
  // Timing of one load or step, in clock edges after the take:
  //   1: service slot, counters move, wait stays high
  //   2: store into the planes, wait drops
  // A slot that meets a pixel tick slips by one edge.
  // Colour and unknown codes store nothing, so wait drops at the slot.
  // PIX_DIV of 1 would leave no slot at all; keep it at 2 or more.
  // Request buffer and write-side state; wait tells the host to hold off
  // Pending requests are serviced only on cycles without a display read,
  // so the scan never loses its slot and refresh stays regular.
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_reg <= 1'b0;
      pend_code_reg <= `VFB_CMD_NOP;
      pend_data_reg <= 8'h00;
      cmd_wait_reg <= 1'b0;
      wr_x_reg <= 8'h00;
      wr_y_reg <= 8'h00;
      colour_reg <= 3'h0;
      do_write_reg <= 1'b0;
    end
    else
    begin
      do_write_reg <= 1'b0;
      if (pend_reg && !pix_tick)
      begin
        // Service slot: update counters, then store the pixel next cycle
        wr_x_reg <= wr_x_next;
        wr_y_reg <= wr_y_next;
        colour_reg <= colour_next;
        do_write_reg <= write_next;
        pend_reg <= 1'b0;
        cmd_wait_reg <= write_next; // held through the store
      end
      else if (cmd_strobe && !pend_reg && !cmd_wait_reg)
      begin
        // Host must not strobe while wait is high; such strobes are dropped
        pend_code_reg <= cmd_code;
        pend_data_reg <= cmd_data;
        pend_reg <= 1'b1;
        cmd_wait_reg <= 1'b1;
      end
      else if (do_write_reg)
        cmd_wait_reg <= 1'b0; // write finished
    end
  end

  // =====================================================
  // Plane write: single bits at Y*256+X, no read path to the host
  always @(posedge sys_clk)
  begin
    if (do_write_reg)
    begin
      plane_r[{wr_y_reg, wr_x_reg}] <= colour_reg[0];
      plane_g[{wr_y_reg, wr_x_reg}] <= colour_reg[1];
      plane_b[{wr_y_reg, wr_x_reg}] <= colour_reg[2];
    end
  end

  // =====================================================
  // Display read: scan of every address doubles as refresh
  // Read happens only on the pixel tick, which is why service slots avoid it
  always @(posedge sys_clk)
  begin
    if (pix_tick)
      rd_bits_reg <= {plane_b[{v_cnt[7:0], h_cnt[7:0]}], plane_g[{v_cnt[7:0], h_cnt[7:0]}],
                      plane_r[{v_cnt[7:0], h_cnt[7:0]}]};
  end

  // =====================================================
  // Sync, blanking and colour outputs, all registered
  // Blank is bit 8 of each counter: columns and lines 256 and up
  // Colour lags the blank flags by one cycle, matching the read latch
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      hblank_reg <= 1'b1;
      vblank_reg <= 1'b1;
      rd_active_reg <= 1'b0;
      rgb_reg <= 3'h0;
    end
    else
    begin
      hsync_reg <= (h_cnt >= `VFB_H_SYNC_START) && (h_cnt < `VFB_H_SYNC_END);
      vsync_reg <= (v_cnt >= `VFB_V_SYNC_START) && (v_cnt < `VFB_V_SYNC_END);
      hblank_reg <= h_cnt[8];
      vblank_reg <= v_cnt[8];
      rd_active_reg <= !h_cnt[8] && !v_cnt[8];
      rgb_reg <= rd_active_reg ? rd_bits_reg : 3'h0;
    end
  end
endmodule // vfb_frame_writer

// ==== verilog/vfb_raster_timer.v ====
// Display read counters and pixel tick generation
`timescale 1ns/1ps
`include "vfb_defines.vh"
module vfb_raster_timer #(
  parameter H_TOTAL = `VFB_H_TOTAL,
  parameter V_TOTAL = `VFB_V_TOTAL,
  parameter PIX_DIV = `VFB_PIX_DIV
)
(
  input wire sys_clk,
  input wire sys_rst,
  output reg pix_tick_reg,
  output reg [8:0] h_cnt_reg,
  output reg [8:0] v_cnt_reg
);
  reg [3:0] div_reg;
  // =====================================================
  // Pixel divider and raster counters
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_reg <= 4'h0;
      pix_tick_reg <= 1'b0;
      h_cnt_reg <= 9'h000;
      v_cnt_reg <= 9'h000;
    end
    else
    begin
      pix_tick_reg <= (div_reg == PIX_DIV[3:0] - 4'h1);
      if (div_reg == PIX_DIV[3:0] - 4'h1)
        div_reg <= 4'h0;
      else
        div_reg <= div_reg + 4'h1;
      if (pix_tick_reg)
      begin
        if (h_cnt_reg == H_TOTAL[8:0] - 9'h001)
        begin
          h_cnt_reg <= 9'h000;
          if (v_cnt_reg == V_TOTAL[8:0] - 9'h001)
            v_cnt_reg <= 9'h000;
          else
            v_cnt_reg <= v_cnt_reg + 9'h001;
        end
        else
          h_cnt_reg <= h_cnt_reg + 9'h001;
      end
    end
  end
endmodule // vfb_raster_timer
